// file: src/asli_pkg.sv
// Shared constants and types for the acked serial link interface.
package asli_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 100;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_W = 8;
  localparam int PTR_W = 32;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_FRAME_BITS = 11;
  localparam int ACK_FRAME_BITS = 3;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic START_LEVEL = 1'h0;
  localparam logic DATA_FLAG = 1'h1;
  localparam logic ACK_FLAG = 1'h0;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_KIND = 5'h04,
    RX_DATA = 5'h08,
    RX_STOP = 5'h10
  } asli_rx_e;
endpackage

// file: src/asli_link_if.sv
// The two one-way serial lines joining the device end and the far end.
interface asli_link_if;
  logic line_to_far;
  logic line_to_dev;
  modport dev (output line_to_far, input line_to_dev);
  modport far (output line_to_dev, input line_to_far);
endinterface

// file: src/asli_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
module asli_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  if (D < 2 || W < 1) begin : g_chk
    $error("asli_fifo needs D >= 2 and W >= 1");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } asli_fifo_s;
  asli_fifo_s s_reg, s_next;
  logic push, pop;
  assign in_ready = (s_reg.cnt != (AW + 1)'(D));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = (s_reg.wr == AW'(D - 1)) ? '0 : AW'(s_reg.wr + 1'b1);
    end
    if (pop) begin
      s_next.rd = (s_reg.rd == AW'(D - 1)) ? '0 : AW'(s_reg.rd + 1'b1);
    end
    s_next.cnt = (AW + 1)'(s_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
endmodule // asli_fifo

// file: src/asli_dev_end.sv
// Link engine and the device end with its transfer registers.
module asli_engine #(
  parameter int BIT_CYCLES = asli_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic line_in,
  output logic line_out,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic ack_seen,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_chk
    $error("asli_engine needs 4 <= BIT_CYCLES <= 65535");
  end
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
  typedef struct packed {
    logic tx_busy;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic ack_wait;
    logic ack_pend;
    logic ack_defer;
    asli_pkg::asli_rx_e rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_sh;
    logic sh_full;
    logic hold_full;
    logic [7:0] hold;
    logic ack_seen;
    logic line_out;
  } asli_eng_s;
  asli_eng_s s_reg, s_next;
  assign line_out = s_reg.line_out;
  assign ack_seen = s_reg.ack_seen;
  assign rx_valid = s_reg.hold_full;
  assign rx_data = s_reg.hold;
  assign tx_ready = !s_reg.tx_busy && !s_reg.ack_pend && !s_reg.ack_wait;
  always_comb begin
    logic ack_req;
    logic ack_rcv;
    ack_req = 1'b0;
    ack_rcv = 1'b0;
    s_next = s_reg;
    s_next.ack_seen = 1'b0;
    if (s_reg.hold_full && rx_ready) begin
      s_next.hold_full = 1'b0;
    end
    if (s_reg.sh_full && !s_next.hold_full) begin
      s_next.hold = s_reg.rx_sh;
      s_next.hold_full = 1'b1;
      s_next.sh_full = 1'b0;
    end
    if (s_reg.ack_defer && !s_next.hold_full && !s_next.sh_full) begin
      s_next.ack_defer = 1'b0;
      ack_req = 1'b1;
    end
    unique case (s_reg.rx_st)
      asli_pkg::RX_IDLE: begin
        // Start is a fall from idle.
        if (line_in == asli_pkg::START_LEVEL) begin
          s_next.rx_st = asli_pkg::RX_START;
          s_next.rx_cnt = '0;
        end
      end
      asli_pkg::RX_START: begin
        if (s_reg.rx_cnt == HALF_LAST) begin
          s_next.rx_cnt = '0;
          s_next.rx_st = (line_in == asli_pkg::START_LEVEL) ? asli_pkg::RX_KIND
                                                              : asli_pkg::RX_IDLE;
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
        end
      end
      asli_pkg::RX_KIND: begin
        if (s_reg.rx_cnt == BIT_LAST) begin
          s_next.rx_cnt = '0;
          // Flag bit tells data from acknowledge.
          if (line_in == asli_pkg::DATA_FLAG) begin
            s_next.rx_st = asli_pkg::RX_DATA;
            s_next.rx_bits = '0;
            if (!s_next.hold_full && !s_next.sh_full) begin
              ack_req = 1'b1;
            end else begin
              s_next.ack_defer = 1'b1;
            end
          end else begin
            s_next.rx_st = asli_pkg::RX_STOP;
            ack_rcv = 1'b1;
          end
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
        end
      end
      asli_pkg::RX_DATA: begin
        if (s_reg.rx_cnt == BIT_LAST) begin
          s_next.rx_cnt = '0;
          s_next.rx_sh = {line_in, s_reg.rx_sh[7:1]};
          s_next.rx_bits = s_reg.rx_bits + 4'h1;
          if (s_reg.rx_bits == 4'h7) begin
            s_next.rx_st = asli_pkg::RX_STOP;
            s_next.sh_full = 1'b1;
          end
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
        end
      end
      asli_pkg::RX_STOP: begin
        if (s_reg.rx_cnt == BIT_LAST) begin
          s_next.rx_cnt = '0;
          s_next.rx_st = asli_pkg::RX_IDLE;
        end else begin
          s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
        end
      end
      default: begin
        s_next.rx_st = asli_pkg::RX_IDLE;
      end
    endcase
    // The old wait is cleared before any new data load can set it again.
    if (ack_rcv) begin
      s_next.ack_wait = 1'b0;
      s_next.ack_seen = 1'b1;
    end
    if (s_reg.tx_busy) begin
      if (s_reg.tx_cnt == BIT_LAST) begin
        s_next.tx_cnt = '0;
        s_next.tx_sh = {asli_pkg::LINE_IDLE, s_reg.tx_sh[10:1]};
        s_next.tx_left = s_reg.tx_left - 4'h1;
        if (s_reg.tx_left == 4'h1) begin
          s_next.tx_busy = 1'b0;
        end
      end else begin
        s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
      end
    end else if (s_reg.ack_pend) begin
      s_next.tx_busy = 1'b1;
      s_next.tx_cnt = '0;
      s_next.ack_pend = 1'b0;
      s_next.tx_sh = {8'hFF, asli_pkg::LINE_IDLE, asli_pkg::ACK_FLAG, asli_pkg::START_LEVEL};
      s_next.tx_left = 4'(asli_pkg::ACK_FRAME_BITS);
    end else if (tx_valid && !s_reg.ack_wait) begin
      s_next.tx_busy = 1'b1;
      s_next.tx_cnt = '0;
      s_next.ack_wait = 1'b1;
      s_next.tx_sh = {asli_pkg::LINE_IDLE, tx_data, asli_pkg::DATA_FLAG, asli_pkg::START_LEVEL};
      s_next.tx_left = 4'(asli_pkg::DATA_FRAME_BITS);
    end
    // A request raised in the same cycle as a send still stands afterwards.
    if (ack_req) begin
      s_next.ack_pend = 1'b1;
    end
    s_next.line_out = s_next.tx_busy ? s_next.tx_sh[0] : asli_pkg::LINE_IDLE;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.rx_st <= asli_pkg::RX_IDLE;
      s_reg.line_out <= asli_pkg::LINE_IDLE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
endmodule // asli_engine

module asli_dev_end #(
  parameter int BIT_CYCLES = asli_pkg::BIT_CYCLES,
  parameter int DEPTH = asli_pkg::FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  asli_link_if.dev LINK,
  input wire logic TX_START,
  input wire logic [asli_pkg::PTR_W-1:0] TX_WPTR_IN,
  input wire logic [asli_pkg::PTR_W-1:0] TX_MPTR_IN,
  input wire logic [asli_pkg::CNT_W-1:0] TX_COUNT_IN,
  output logic TX_BUSY,
  input wire logic SRC_VALID,
  input wire logic [7:0] SRC_DATA,
  output logic SRC_READY,
  output logic [asli_pkg::PTR_W-1:0] TX_MPTR,
  output logic TX_DONE,
  output logic [asli_pkg::PTR_W-1:0] TX_DONE_WPTR,
  input wire logic RX_START,
  input wire logic [asli_pkg::PTR_W-1:0] RX_WPTR_IN,
  input wire logic [asli_pkg::PTR_W-1:0] RX_MPTR_IN,
  input wire logic [asli_pkg::CNT_W-1:0] RX_COUNT_IN,
  output logic RX_BUSY,
  output logic DST_VALID,
  output logic [7:0] DST_DATA,
  output logic [asli_pkg::PTR_W-1:0] DST_ADDR,
  input wire logic DST_READY,
  output logic RX_DONE,
  output logic [asli_pkg::PTR_W-1:0] RX_DONE_WPTR
);
  localparam int PW = asli_pkg::PTR_W;
  localparam int CW = asli_pkg::CNT_W;
  typedef struct packed {
    logic tx_act;
    logic [PW-1:0] tx_wptr;
    logic [PW-1:0] tx_mptr;
    logic [CW-1:0] tx_count;
    logic [CW-1:0] tx_left;
    logic tx_done;
    logic [PW-1:0] tx_done_wptr;
    logic rx_act;
    logic [PW-1:0] rx_wptr;
    logic [PW-1:0] rx_mptr;
    logic [CW-1:0] rx_count;
    logic rx_done;
    logic [PW-1:0] rx_done_wptr;
  } asli_dev_s;
  asli_dev_s s_reg, s_next;
  logic f_valid, f_ready, e_ready, e_ack, e_rx_valid, e_rx_ready, e_tx_valid;
  logic [7:0] f_data;
  asli_fifo #(.W(8), .D(DEPTH)) i_asli_fifo (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .in_valid(SRC_VALID),
    .in_data(SRC_DATA),
    .in_ready(SRC_READY),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );
  // One line out, one line in.
  asli_engine #(.BIT_CYCLES(BIT_CYCLES)) i_asli_engine (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .line_in(LINK.line_to_dev),
    .line_out(LINK.line_to_far),
    .tx_valid(e_tx_valid),
    .tx_data(f_data),
    .tx_ready(e_ready),
    .ack_seen(e_ack),
    .rx_valid(e_rx_valid),
    .rx_data(DST_DATA),
    .rx_ready(e_rx_ready)
  );
  // One byte per frame, counted down.
  assign e_tx_valid = s_reg.tx_act && (s_reg.tx_left != '0) && f_valid;
  assign f_ready = s_reg.tx_act && (s_reg.tx_left != '0) && e_ready;
  assign DST_VALID = s_reg.rx_act && e_rx_valid;
  assign e_rx_ready = s_reg.rx_act && DST_READY;
  assign TX_BUSY = s_reg.tx_act;
  assign RX_BUSY = s_reg.rx_act;
  assign TX_MPTR = s_reg.tx_mptr;
  assign DST_ADDR = s_reg.rx_mptr;
  assign TX_DONE = s_reg.tx_done;
  assign TX_DONE_WPTR = s_reg.tx_done_wptr;
  assign RX_DONE = s_reg.rx_done;
  assign RX_DONE_WPTR = s_reg.rx_done_wptr;
  always_comb begin
    s_next = s_reg;
    s_next.tx_done = 1'b0;
    s_next.rx_done = 1'b0;
    if (!s_reg.tx_act) begin
      if (TX_START) begin
        s_next.tx_act = 1'b1;
        s_next.tx_wptr = TX_WPTR_IN;
        s_next.tx_mptr = TX_MPTR_IN;
        s_next.tx_count = TX_COUNT_IN;
        s_next.tx_left = TX_COUNT_IN;
      end
    end else begin
      if (f_valid && f_ready) begin
        s_next.tx_mptr = s_reg.tx_mptr + PW'(1);
        s_next.tx_left = s_reg.tx_left - CW'(1);
      end
      if (e_ack && s_reg.tx_count != '0) begin
        s_next.tx_count = s_reg.tx_count - CW'(1);
      end
      if (s_reg.tx_count == '0 || (e_ack && s_reg.tx_count == CW'(1))) begin
        s_next.tx_act = 1'b0;
        s_next.tx_done = 1'b1;
        s_next.tx_done_wptr = s_reg.tx_wptr;
      end
    end
    if (!s_reg.rx_act) begin
      if (RX_START) begin
        s_next.rx_act = 1'b1;
        s_next.rx_wptr = RX_WPTR_IN;
        s_next.rx_mptr = RX_MPTR_IN;
        s_next.rx_count = RX_COUNT_IN;
      end
    end else begin
      if (DST_VALID && DST_READY) begin
        s_next.rx_mptr = s_reg.rx_mptr + PW'(1);
        s_next.rx_count = s_reg.rx_count - CW'(1);
      end
      // Reschedule request when message is in.
      if (s_reg.rx_count == '0 || (DST_VALID && DST_READY && s_reg.rx_count == CW'(1))) begin
        s_next.rx_act = 1'b0;
        s_next.rx_done = 1'b1;
        s_next.rx_done_wptr = s_reg.rx_wptr;
      end
    end
  end
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s_reg <= '0;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end
endmodule // asli_dev_end

// file: src/asli_far_end.sv
// Far end of the link: plain byte streams over the same engine.
module asli_far_end #(
  parameter int BIT_CYCLES = asli_pkg::BIT_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  asli_link_if.far LINK,
  input wire logic SEND_VALID,
  input wire logic [7:0] SEND_DATA,
  output logic SEND_READY,
  output logic SEND_ACKED,
  output logic RECV_VALID,
  output logic [7:0] RECV_DATA,
  input wire logic RECV_READY
);
  // The peer keeps the same framing and acknowledge discipline, so it reuses the engine.
  asli_engine #(.BIT_CYCLES(BIT_CYCLES)) i_asli_engine (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .line_in(LINK.line_to_far),
    .line_out(LINK.line_to_dev),
    .tx_valid(SEND_VALID),
    .tx_data(SEND_DATA),
    .tx_ready(SEND_READY),
    .ack_seen(SEND_ACKED),
    .rx_valid(RECV_VALID),
    .rx_data(RECV_DATA),
    .rx_ready(RECV_READY)
  );
endmodule // asli_far_end

// file: dv/asli_link_props.sv
// Checker for the two serial lines between the link ends.
module asli_link_props #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic line_to_far,
  input wire logic line_to_dev
);
  if (BIT_CYCLES != 4) begin : g_chk
    $error("asli_link_props repetition counts need BIT_CYCLES == 4");
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  int low_far_reg;
  int low_dev_reg;
  // Repetition counts below assume four clocks per bit.
  // A zero byte after the flag bit is the longest legal low run.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      low_far_reg <= 0;
      low_dev_reg <= 0;
    end else begin
      low_far_reg <= line_to_far ? 0 : low_far_reg + 1;
      low_dev_reg <= line_to_dev ? 0 : low_dev_reg + 1;
    end
  end
  far_frame_shape_a: assert property ($fell(line_to_far) |-> (!line_to_far)[*4] ##1
    (line_to_far[*4] or ((!line_to_far)[*4] ##1 line_to_far[*4])))
    else $error("far line frame does not start as data or acknowledge");
  dev_frame_shape_a: assert property ($fell(line_to_dev) |-> (!line_to_dev)[*4] ##1
    (line_to_dev[*4] or ((!line_to_dev)[*4] ##1 line_to_dev[*4])))
    else $error("dev line frame does not start as data or acknowledge");
  far_low_bound_a: assert property (low_far_reg <= 8 * BIT_CYCLES)
    else $error("far line low too long, stop bit missing");
  dev_low_bound_a: assert property (low_dev_reg <= 8 * BIT_CYCLES)
    else $error("dev line low too long, stop bit missing");
  far_high_hold_a: assert property ($rose(line_to_far) |-> line_to_far[*4])
    else $error("far line high level shorter than one bit");
  dev_high_hold_a: assert property ($rose(line_to_dev) |-> line_to_dev[*4])
    else $error("dev line high level shorter than one bit");
  far_reset_idle_a: assert property ($fell(RESET) |-> line_to_far[*2])
    else $error("far line not idle after reset");
  dev_reset_idle_a: assert property ($fell(RESET) |-> line_to_dev[*2])
    else $error("dev line not idle after reset");
  cover property ($fell(line_to_far) ##4 line_to_far);
  cover property ($fell(line_to_far) ##4 !line_to_far ##4 line_to_far);
  cover property ($fell(line_to_dev) ##4 !line_to_dev ##4 line_to_dev);
endmodule // asli_link_props

// file: dv/asli_bench.sv
// Self-checking bench joining the device end and the far end over one link.
module asli_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 4;
  localparam int LIMIT = 20000;
  logic clk, rst = 1'b1, ce = 1'b1, dst_ready = 1'b1, recv_ready = 1'b1;
  logic tx_start = 1'b0, rx_start = 1'b0, src_valid = 1'b0, send_valid = 1'b0;
  logic [7:0] src_data = 8'h00, send_data = 8'h00, dst_data, recv_data;
  logic [31:0] tx_wptr = 32'h0000_0000, tx_mptr = 32'h0000_0000;
  logic [31:0] rx_wptr = 32'h0000_0000, rx_mptr = 32'h0000_0000;
  logic [15:0] tx_cnt = 16'h0000, rx_cnt = 16'h0000;
  logic tx_busy, src_ready, tx_done, rx_busy, dst_valid, rx_done, send_ready, recv_valid;
  logic send_acked;
  logic [31:0] tx_mptr_o, tx_done_wptr, dst_addr, rx_done_wptr;
  logic [7:0] far_q[$], dev_q[$];
  logic [31:0] addr_q[$];
  int errors = 0, checks_done = 0, cycles = 0, tx_dn = 0, rx_dn = 0, ack_n = 0, t0;

  asli_link_if i_asli_link_if ();
  asli_dev_end #(.BIT_CYCLES(BC), .DEPTH(8)) i_asli_dev_end (
    .REF_CLK(clk), .RESET(rst), .CE(ce), .LINK(i_asli_link_if.dev),
    .TX_START(tx_start), .TX_WPTR_IN(tx_wptr), .TX_MPTR_IN(tx_mptr), .TX_COUNT_IN(tx_cnt),
    .TX_BUSY(tx_busy), .SRC_VALID(src_valid), .SRC_DATA(src_data), .SRC_READY(src_ready),
    .TX_MPTR(tx_mptr_o), .TX_DONE(tx_done), .TX_DONE_WPTR(tx_done_wptr),
    .RX_START(rx_start), .RX_WPTR_IN(rx_wptr), .RX_MPTR_IN(rx_mptr), .RX_COUNT_IN(rx_cnt),
    .RX_BUSY(rx_busy), .DST_VALID(dst_valid), .DST_DATA(dst_data), .DST_ADDR(dst_addr),
    .DST_READY(dst_ready), .RX_DONE(rx_done), .RX_DONE_WPTR(rx_done_wptr));
  asli_far_end #(.BIT_CYCLES(BC)) i_asli_far_end (
    .REF_CLK(clk), .RESET(rst), .CE(ce), .LINK(i_asli_link_if.far),
    .SEND_VALID(send_valid), .SEND_DATA(send_data), .SEND_READY(send_ready),
    .SEND_ACKED(send_acked),
    .RECV_VALID(recv_valid), .RECV_DATA(recv_data), .RECV_READY(recv_ready));
  asli_link_props #(.BIT_CYCLES(BC)) i_asli_link_props (
    .REF_CLK(clk), .RESET(rst), .line_to_far(i_asli_link_if.line_to_far),
    .line_to_dev(i_asli_link_if.line_to_dev));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input int i, input logic [7:0] b);
    return b ^ 8'(i * 8'h35);
  endfunction

  task automatic chk_q(ref logic [7:0] q[$], input int n, input logic [7:0] b);
    // An early acknowledge ends a send while its last byte is still on the line.
    for (int k = 0; k < 12 * BC && q.size() < n; k++) @(posedge clk);
    chk(32'(q.size()), 32'(n));
    for (int i = 0; i < n && i < q.size(); i++) chk({24'h00_0000, q[i]}, {24'h00_0000, pat(i, b)});
    q.delete();
  endtask

  task automatic wait_cnt(ref int c, input int t, input int lim);
    for (int k = 0; k < lim && c < t; k++) @(posedge clk);
    chk(32'(c), 32'(t));
  endtask

  task automatic tx_begin(input int n);
    @(posedge clk);
    tx_start <= 1'b1;
    tx_wptr <= 32'h0000_1000 + 32'(n);
    tx_mptr <= 32'h0000_2000;
    tx_cnt <= 16'(n);
    @(posedge clk);
    tx_start <= 1'b0;
  endtask

  task automatic push_src(input logic [7:0] d);
    src_valid <= 1'b1;
    src_data <= d;
    @(negedge clk);
    while (src_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic dev_send(input int n, input logic [7:0] b);
    tx_begin(n);
    for (int i = 0; i < n; i++) push_src(pat(i, b));
    src_valid <= 1'b0;
  endtask

  task automatic far_send(input int n, input logic [7:0] b);
    @(posedge clk);
    rx_start <= 1'b1;
    rx_wptr <= 32'h0000_3000 + 32'(n);
    rx_mptr <= 32'h0000_4000;
    rx_cnt <= 16'(n);
    @(posedge clk);
    rx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      send_valid <= 1'b1;
      send_data <= pat(i, b);
      @(negedge clk);
      while (send_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    send_valid <= 1'b0;
  endtask

  // Sampled on the falling edge, where everything the next rising edge uses has settled.
  always @(negedge clk) begin
    cycles <= cycles + 1;
    if (ce === 1'b1) begin
      if (recv_valid === 1'b1 && recv_ready === 1'b1) far_q.push_back(recv_data);
      if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
        dev_q.push_back(dst_data);
        addr_q.push_back(dst_addr);
      end
      if (tx_done === 1'b1) tx_dn <= tx_dn + 1;
      if (rx_done === 1'b1) rx_dn <= rx_dn + 1;
      if (send_acked === 1'b1) ack_n <= ack_n + 1;
    end
    // A hang ends the run as a failure rather than stalling forever.
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    fork
      dev_send(5, 8'hA5);
      far_send(4, 8'h3C);
    join
    wait_cnt(tx_dn, 1, 2000);
    wait_cnt(rx_dn, 1, 2000);
    chk_q(far_q, 5, 8'hA5);
    chk(tx_done_wptr, 32'h0000_1005);
    chk(tx_mptr_o, 32'h0000_2005);
    chk(rx_done_wptr, 32'h0000_3004);
    chk(32'(rx_busy), 32'h0000_0000);
    for (int i = 0; i < 4 && i < addr_q.size(); i++) chk(addr_q[i], 32'h0000_4000 + 32'(i));
    addr_q.delete();
    chk_q(dev_q, 4, 8'h3C);
    // Far end holds its bytes, so the second acknowledge must be withheld.
    recv_ready <= 1'b0;
    dev_send(4, 8'h0F);
    repeat (200) @(posedge clk);
    chk(tx_mptr_o, 32'h0000_2002);
    chk(32'(tx_busy), 32'h0000_0001);
    chk(32'(tx_dn), 32'h0000_0001);
    chk(32'(ack_n), 32'h0000_0004);
    // A low enable freezes both ends, so the drained byte must not release the sender yet.
    ce <= 1'b0;
    recv_ready <= 1'b1;
    repeat (100) @(posedge clk);
    chk(32'(tx_dn), 32'h0000_0001);
    ce <= 1'b1;
    wait_cnt(tx_dn, 2, 2000);
    chk_q(far_q, 4, 8'h0F);
    dev_send(0, 8'h00);
    wait_cnt(tx_dn, 3, 6);
    for (int i = 0; i < 8; i++) push_src(pat(i, 8'h5A));
    src_data <= 8'hEE;
    @(negedge clk);
    chk(32'(src_ready), 32'h0000_0000);
    @(posedge clk);
    src_valid <= 1'b0;
    t0 = cycles;
    tx_begin(8);
    wait_cnt(tx_dn, 4, 2000);
    chk(32'(cycles - t0 <= 8 * 11 * BC), 32'h0000_0001);
    chk_q(far_q, 8, 8'h5A);
    final_report();
  end
endmodule // asli_bench
